//--- design/mcd_top.sv
// Machine check frame capture and vector dispatch unit
// Notes on behaviour
// [RL1] On a machine check the shift count is written to the frame word at stack pointer plus 24.
// [RL2] The frame holds the full 32-bit address of the first byte of the checked instruction.
// [RL3] The frame holds the whole 32-bit status longword as it stood at the check.
// [RL4] The acknowledge register sits at index 38, is write-only and reads as nothing.
// [RL5] Invoking the handler sets a busy flag; a new check or memory fault then halts instead.
// [RL6] Software writes zero to the acknowledge register early to clear the busy flag.
// [RL7] Vectors come from a two-page table whose base is register index 17.
// [RL8] The base register holds a physical longword address with zero bits above and below.
// [RL9] Kernel stack not valid dispatches as an abort at offset 08, no parameters, interrupt stack.
// [RL10] A memory soft error dispatches at offset 54 with level 1A.
// [RL11] A memory hard error dispatches at offset 60, no parameters, level 1D.
// [RL12] An external interrupt indexes the table with bits 15 to 2 of its vector.
// [RL13] Vector bit 0 clear takes the level from the request; set leaves it to software.
// [RL14] Handler software finds the device level and sets the priority level itself.
// [RL15] External hardware keeps vectors within 100 to 400 hex except console emulators.
// [RL16] A machine check dispatches as an abort at offset 04 with six parameters.
//
// Decided for this implementation: the AXI4-Lite register port.
module mcd_top
  import mcd_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite
  input wire logic [mcd_pkg::ADDR_W-1:0] s_awaddr,
  input wire logic [2:0] s_awprot,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [mcd_pkg::ADDR_W-1:0] s_araddr,
  input wire logic [2:0] s_arprot,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // Processor state
  input wire logic [31:0] cur_sp,
  input wire logic [31:0] cur_sc,
  input wire logic [31:0] cur_psl,
  input wire logic [31:0] inst_pc,
  // Event requests
  input wire logic mchk_req,
  input wire logic mm_exc,
  input wire logic ksnv_req,
  input wire logic soft_err_req,
  input wire logic hard_err_req,
  input wire logic ext_req,
  input wire logic [1:0] ext_level,
  input wire logic [15:0] ext_vector,
  // Frame writes
  output logic frame_we,
  output logic [31:0] frame_addr,
  output logic [31:0] frame_data,
  // Dispatch
  output logic req_accept,
  output logic disp_valid,
  output logic [31:0] disp_addr,
  output logic [4:0] disp_ipl,
  output logic [3:0] disp_params,
  output logic disp_abort,
  output logic disp_istack,
  output logic dbl_halt,
  output logic mchk_busy,
  output logic irq
);
  mcd_state_t state_reg;
  logic [31:0] vtb_reg;
  logic [EVT_W-1:0] status_reg;
  logic [EVT_W-1:0] mask_reg;
  logic [31:0] sp_reg;
  logic [31:0] sc_reg;
  logic [31:0] pc_reg;
  logic [31:0] psl_reg;
  logic [EVT_W-1:0] evt_set;
  logic wr_en;
  logic wr_ok;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [31:0] rd_data;
  logic rd_ok;
  logic idle;
  logic halt_now;
  logic ack_wr;

  function automatic logic [31:0] vec_addr(input logic [31:0] base, input logic [31:0] off);
    vec_addr = base + off;
  endfunction

  function automatic logic [4:0] ext_ipl(input logic [15:0] vec, input logic [1:0] lvl,
                                         input logic [31:0] processor_status_longword);
    ext_ipl = vec[0] ? processor_status_longword[20:16] : IPL_EXT_BASE + {3'h0, lvl};
  endfunction

  // ----------------------------------------
  // Bus front end
  // ----------------------------------------
  mcd_axil_slave u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid),
    .s_awready(s_awready),
    .s_wdata(s_wdata),
    .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid),
    .s_wready(s_wready),
    .s_bresp(s_bresp),
    .s_bvalid(s_bvalid),
    .s_bready(s_bready),
    .s_arvalid(s_arvalid),
    .s_arready(s_arready),
    .s_rdata(s_rdata),
    .s_rresp(s_rresp),
    .s_rvalid(s_rvalid),
    .s_rready(s_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_ok(wr_ok),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  // ----------------------------------------
  // Register decode
  // ----------------------------------------
  assign ack_wr = wr_en && wr_addr == ADDR_ACK && wr_data == 32'h0000_0000; // [RL6]
  assign wr_ok = wr_addr == ADDR_VTB || wr_addr == ADDR_ACK || wr_addr == ADDR_STATUS ||
                 wr_addr == ADDR_MASK;

  always_comb begin
    rd_data = 32'h0000_0000;
    rd_ok = 1'b1;
    case (s_araddr)
      ADDR_VTB: rd_data = vtb_reg; // [RL7]
      ADDR_ACK: rd_data = 32'h0000_0000; // [RL4]
      ADDR_STATUS: rd_data = {29'h0, status_reg};
      ADDR_MASK: rd_data = {29'h0, mask_reg};
      ADDR_STATE: rd_data = {27'h0, state_reg[4:1] != 4'h0, mchk_busy, 2'h0, idle};
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vtb_reg <= RST_VTB;
    end else if (wr_en && wr_addr == ADDR_VTB) begin
      for (int i = 0; i < 4; i++) begin
        if (wr_strb[i]) vtb_reg[8*i +: 8] <= wr_data[8*i +: 8] & VTB_WRITABLE[8*i +: 8]; // [RL8]
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_reg <= RST_MASK;
    end else if (wr_en && wr_addr == ADDR_MASK && wr_strb[0]) begin
      mask_reg <= wr_data[EVT_W-1:0];
    end
  end

  // ----------------------------------------
  // Interrupt status
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_reg <= '0;
      irq <= 1'b0;
    end else begin
      if (wr_en && wr_addr == ADDR_STATUS && wr_strb[0]) begin
        status_reg <= (status_reg & ~wr_data[EVT_W-1:0]) | evt_set;
      end else begin
        status_reg <= status_reg | evt_set;
      end
      irq <= |((status_reg | evt_set) & mask_reg);
    end
  end

  // ----------------------------------------
  // Event sequencer
  // ----------------------------------------
  assign idle = state_reg == ST_IDLE && !req_accept; // Held request not taken twice
  assign halt_now = idle && mchk_busy && (mchk_req || mm_exc); // [RL5]
  assign evt_set = {idle && !mchk_req && !mm_exc && !ksnv_req && !hard_err_req &&
                    !soft_err_req && ext_req, halt_now, state_reg == ST_DISP};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: state_reg <= (idle && mchk_req && !mchk_busy) ? ST_SC : ST_IDLE;
        ST_SC: state_reg <= ST_PC;
        ST_PC: state_reg <= ST_PSL;
        ST_PSL: state_reg <= ST_DISP;
        ST_DISP: state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sp_reg <= '0;
      sc_reg <= '0;
      pc_reg <= '0;
      psl_reg <= '0;
    end else if (idle && mchk_req && !mchk_busy) begin
      sp_reg <= cur_sp;
      sc_reg <= cur_sc; // [RL1]
      pc_reg <= inst_pc; // [RL2]
      psl_reg <= cur_psl; // [RL3]
    end
  end

  // ----------------------------------------
  // Frame writes
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_we <= 1'b0;
      frame_addr <= '0;
      frame_data <= '0;
    end else begin
      frame_we <= state_reg == ST_SC || state_reg == ST_PC || state_reg == ST_PSL;
      case (state_reg)
        ST_SC: begin
          frame_addr <= sp_reg + FRAME_SC_OFF; // [RL1]
          frame_data <= sc_reg;
        end
        ST_PC: begin
          frame_addr <= sp_reg + FRAME_PC_OFF; // [RL2]
          frame_data <= pc_reg;
        end
        ST_PSL: begin
          frame_addr <= sp_reg + FRAME_PSL_OFF; // [RL3]
          frame_data <= psl_reg;
        end
        default: begin
          frame_addr <= frame_addr;
          frame_data <= frame_data;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Busy flag
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mchk_busy <= 1'b0;
    end else if (state_reg == ST_DISP) begin
      mchk_busy <= 1'b1; // [RL5]
    end else if (ack_wr) begin
      mchk_busy <= 1'b0; // [RL6]
    end
  end

  // ----------------------------------------
  // Dispatch
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_accept <= 1'b0;
      disp_valid <= 1'b0;
      disp_addr <= '0;
      disp_ipl <= '0;
      disp_params <= '0;
      disp_abort <= 1'b0;
      disp_istack <= 1'b0;
      dbl_halt <= 1'b0;
    end else begin
      req_accept <= idle && (mchk_req || ksnv_req || hard_err_req || soft_err_req ||
                             ext_req || halt_now);
      dbl_halt <= halt_now; // [RL5]
      disp_valid <= 1'b0;
      disp_params <= 4'h0;
      disp_abort <= 1'b0;
      disp_istack <= 1'b0;
      disp_ipl <= cur_psl[20:16];
      if (state_reg == ST_DISP) begin
        disp_valid <= 1'b1;
        disp_addr <= vec_addr(vtb_reg, VEC_MCHK); // [RL16]
        disp_params <= MCHK_PARAMS; // [RL16]
        disp_abort <= 1'b1;
        disp_ipl <= psl_reg[20:16];
      end else if (idle && !mchk_req && !mm_exc) begin
        if (ksnv_req) begin
          disp_valid <= 1'b1;
          disp_addr <= vec_addr(vtb_reg, VEC_KSNV); // [RL9]
          disp_abort <= 1'b1;
          disp_istack <= 1'b1; // [RL9]
        end else if (hard_err_req) begin
          disp_valid <= 1'b1;
          disp_addr <= vec_addr(vtb_reg, VEC_HARD); // [RL11]
          disp_ipl <= IPL_HARD;
        end else if (soft_err_req) begin
          disp_valid <= 1'b1;
          disp_addr <= vec_addr(vtb_reg, VEC_SOFT); // [RL10]
          disp_ipl <= IPL_SOFT;
        end else if (ext_req) begin
          disp_valid <= 1'b1;
          disp_addr <= vec_addr(vtb_reg, {16'h0, ext_vector[15:2], 2'b00}); // [RL12] [RL7]
          disp_ipl <= ext_ipl(ext_vector, ext_level, cur_psl); // [RL13]
        end
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_sc_word;
    @(posedge aclk) disable iff (!aresetn)
    state_reg == ST_SC |=> frame_we && frame_addr == $past(cur_sp, 2) + 32'h0000_0018 &&
      frame_data == $past(cur_sc, 2) ##1 frame_we ##1 frame_we;
  endproperty
  a_sc_word: assert property (p_sc_word) else $error("shift count frame word wrong"); // [RL1]
  property p_pc_word;
    @(posedge aclk) disable iff (!aresetn)
    state_reg == ST_PC |=> frame_addr == $past(cur_sp, 3) + 32'h0000_001C &&
      frame_data == $past(inst_pc, 3);
  endproperty
  a_pc_word: assert property (p_pc_word) else $error("pc frame word wrong"); // [RL2]
  property p_psl_word;
    @(posedge aclk) disable iff (!aresetn)
    state_reg == ST_PSL |=> frame_data == $past(cur_psl, 4) ##1 disp_valid && disp_abort;
  endproperty
  a_psl_word: assert property (p_psl_word) else $error("psl frame word wrong"); // [RL3]
  property p_ack_reads_zero;
    @(posedge aclk) disable iff (!aresetn)
    s_arvalid && s_arready && s_araddr == ADDR_ACK |=> s_rvalid && s_rdata == 32'h0000_0000;
  endproperty
  a_ack_reads_zero: assert property (p_ack_reads_zero) else $error("ack read not zero"); // [RL4]
  property p_double_halt;
    @(posedge aclk) disable iff (!aresetn)
    idle && mchk_busy && (mchk_req || mm_exc) |=> dbl_halt && !disp_valid &&
      state_reg == ST_IDLE;
  endproperty
  a_double_halt: assert property (p_double_halt) else $error("no double error halt"); // [RL5]
  property p_ack_clears;
    @(posedge aclk) disable iff (!aresetn)
    ack_wr && state_reg != ST_DISP |=> !mchk_busy;
  endproperty
  a_ack_clears: assert property (p_ack_clears) else $error("busy flag not cleared"); // [RL6]
  property p_vtb_mbz;
    @(posedge aclk) disable iff (!aresetn)
    vtb_reg[31:30] == 2'b00 && vtb_reg[8:0] == 9'h000;
  endproperty
  a_vtb_mbz: assert property (p_vtb_mbz) else $error("base reserved bits set"); // [RL8]
  property p_mchk_vec;
    @(posedge aclk) disable iff (!aresetn)
    idle && mchk_req && !mchk_busy |-> ##5 disp_valid && disp_params == 4'h6 &&
      disp_addr == vtb_reg + 32'h0000_0004;
  endproperty
  a_mchk_vec: assert property (p_mchk_vec) else $error("machine check vector wrong"); // [RL16]
  property p_ksnv;
    @(posedge aclk) disable iff (!aresetn)
    idle && ksnv_req && !mchk_req && !mm_exc |=> disp_istack && disp_params == 4'h0 &&
      disp_addr == $past(vtb_reg) + 32'h0000_0008;
  endproperty
  a_ksnv: assert property (p_ksnv) else $error("stack invalid dispatch wrong"); // [RL9]
  property p_hard;
    @(posedge aclk) disable iff (!aresetn)
    idle && hard_err_req && !ksnv_req && !mchk_req && !mm_exc |=> disp_ipl == 5'h1D &&
      disp_addr == $past(vtb_reg) + 32'h0000_0060;
  endproperty
  a_hard: assert property (p_hard) else $error("hard error dispatch wrong"); // [RL11]
  property p_soft;
    @(posedge aclk) disable iff (!aresetn)
    disp_valid && disp_addr == vtb_reg + 32'h0000_0054 && !$past(ext_req) |-> disp_ipl == 5'h1A;
  endproperty
  a_soft: assert property (p_soft) else $error("soft error level wrong"); // [RL10]
  property p_ext;
    @(posedge aclk) disable iff (!aresetn)
    evt_set[EVT_EXT] && !ext_vector[0] |=> disp_valid &&
      disp_ipl == 5'h14 + {3'h0, $past(ext_level)} &&
      disp_addr[15:2] == $past(vtb_reg[15:2]) + $past(ext_vector[15:2]);
  endproperty
  a_ext: assert property (p_ext) else $error("external dispatch wrong"); // [RL12] [RL13]
  c_mchk: cover property (@(posedge aclk) disable iff (!aresetn) state_reg == ST_DISP);
  c_halt: cover property (@(posedge aclk) disable iff (!aresetn) dbl_halt);
  c_ext: cover property (@(posedge aclk) disable iff (!aresetn) evt_set[EVT_EXT] && irq);
endmodule

//--- pkg/mcd_pkg.sv
// Constants and types for the machine check and vector dispatch unit
package mcd_pkg;
  // ----------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [9:0] IDX_VTB = 10'h011;
  localparam logic [9:0] IDX_ACK = 10'h026;
  localparam logic [9:0] IDX_STATUS = 10'h040;
  localparam logic [9:0] IDX_MASK = 10'h041;
  localparam logic [9:0] IDX_STATE = 10'h042;
  localparam logic [ADDR_W-1:0] ADDR_VTB = {IDX_VTB, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_ACK = {IDX_ACK, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_MASK = {IDX_MASK, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_STATE = {IDX_STATE, 2'b00};
  // ----------------------------------------
  // Fields and reset values
  // ----------------------------------------
  localparam logic [31:0] VTB_WRITABLE = 32'h3FFF_FE00;
  localparam logic [31:0] RST_VTB = 32'h0000_0000;
  localparam int EVT_W = 3;
  localparam int EVT_MCHK = 0;
  localparam int EVT_HALT = 1;
  localparam int EVT_EXT = 2;
  localparam logic [EVT_W-1:0] RST_MASK = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------
  // Stack frame and vector table
  // ----------------------------------------
  localparam logic [31:0] FRAME_SC_OFF = 32'h0000_0018;
  localparam logic [31:0] FRAME_PC_OFF = 32'h0000_001C;
  localparam logic [31:0] FRAME_PSL_OFF = 32'h0000_0020;
  localparam logic [31:0] VEC_MCHK = 32'h0000_0004;
  localparam logic [31:0] VEC_KSNV = 32'h0000_0008;
  localparam logic [31:0] VEC_SOFT = 32'h0000_0054;
  localparam logic [31:0] VEC_HARD = 32'h0000_0060;
  localparam logic [3:0] MCHK_PARAMS = 4'h6;
  localparam logic [4:0] IPL_SOFT = 5'h1A;
  localparam logic [4:0] IPL_HARD = 5'h1D;
  localparam logic [4:0] IPL_EXT_BASE = 5'h14;
  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_SC = 5'b00010,
    ST_PC = 5'b00100,
    ST_PSL = 5'b01000,
    ST_DISP = 5'b10000
  } mcd_state_t;
endpackage

//--- design/mcd_axil_slave.sv
// AXI4-Lite slave front end for the dispatch unit registers
module mcd_axil_slave
  import mcd_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite
  input wire logic [mcd_pkg::ADDR_W-1:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // Register file side
  output logic wr_en,
  output logic [mcd_pkg::ADDR_W-1:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_ok,
  input wire logic [31:0] rd_data,
  input wire logic rd_ok
);
  logic aw_full_reg;
  logic w_full_reg;
  logic aw_full_next;
  logic w_full_next;

  // ----------------------------------------
  // Write channels
  // ----------------------------------------
  assign wr_en = aw_full_reg && w_full_reg && !s_bvalid;

  always_comb begin
    aw_full_next = aw_full_reg;
    w_full_next = w_full_reg;
    if (s_awvalid && s_awready) aw_full_next = 1'b1;
    if (s_wvalid && s_wready) w_full_next = 1'b1;
    if (wr_en) begin
      aw_full_next = 1'b0;
      w_full_next = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      s_awready <= 1'b0;
      s_wready <= 1'b0;
      s_bvalid <= 1'b0;
      s_bresp <= RESP_OKAY;
      wr_addr <= '0;
      wr_data <= '0;
      wr_strb <= '0;
    end else begin
      aw_full_reg <= aw_full_next;
      w_full_reg <= w_full_next;
      s_awready <= !aw_full_next && !(wr_en || (s_bvalid && !s_bready));
      s_wready <= !w_full_next && !(wr_en || (s_bvalid && !s_bready));
      if (s_awvalid && s_awready) wr_addr <= s_awaddr;
      if (s_wvalid && s_wready) begin
        wr_data <= s_wdata;
        wr_strb <= s_wstrb;
      end
      if (wr_en) begin
        s_bvalid <= 1'b1;
        s_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Read channels
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b0;
      s_rdata <= '0;
      s_rresp <= RESP_OKAY;
    end else if (s_arvalid && s_arready) begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b1;
      s_rdata <= rd_data;
      s_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_rvalid && s_rready) begin
      s_rvalid <= 1'b0;
      s_arready <= 1'b1;
    end else if (!s_rvalid) begin
      s_arready <= 1'b1;
    end
  end
endmodule

//--- verification/mcd_ext_irq.sv
// Model of the external interrupt hardware feeding vectors and levels
module mcd_ext_irq (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Request handshake
  input wire logic req_accept,
  output logic ext_req,
  output logic [1:0] ext_level,
  output logic [15:0] ext_vector
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    ext_req = 1'b0;
    ext_level = 2'h0;
    ext_vector = 16'h0000;
  end
  // Holds the request until accepted, then scrambles the released lines
  task automatic send(input logic [15:0] vec, input logic [1:0] lvl);
    @(posedge aclk);
    ext_req <= 1'b1;
    ext_vector <= vec;
    ext_level <= lvl;
    do @(posedge aclk); while (req_accept !== 1'b1);
    ext_req <= 1'b0;
    ext_vector <= ~vec;
    ext_level <= ~lvl;
  endtask
endmodule

//--- verification/mcd_top_bench.sv
// Self-checking bench for the machine check and vector dispatch unit
module mcd_top_bench;
  import mcd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] BASE = 32'h0001_0200;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [ADDR_W-1:0] s_awaddr = '0, s_araddr = '0;
  logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
  logic [31:0] s_wdata = '0;
  logic [3:0] s_wstrb = 4'hF;
  logic [2:0] s_awprot = 3'h0, s_arprot = 3'h0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, ext_req, mm_exc = 1'b0;
  logic [1:0] s_bresp, s_rresp, ext_level, rsp;
  logic [31:0] s_rdata, frame_addr, frame_data, disp_addr, d_addr, rd;
  logic [31:0] cur_sp = 32'h0000_8000, cur_sc = 32'h0000_0013;
  logic [31:0] cur_psl = 32'h0417_0000, inst_pc = 32'h0000_2468;
  logic [3:0] rq = 4'h0;
  logic [15:0] ext_vector;
  logic frame_we, req_accept, disp_valid, disp_abort, disp_istack, dbl_halt, mchk_busy, irq;
  logic [4:0] disp_ipl, d_ipl;
  logic [3:0] disp_params, d_par;
  logic d_abt, d_ist;
  logic [31:0] fa [3], fd [3];
  logic [31:0] voff [4] = '{32'h0, 32'h8, 32'h54, 32'h60};
  logic [31:0] vipl [4] = '{32'h0, 32'h17, 32'h1A, 32'h1D};
  int fails = 0, cmp_count = 0, nd = 0, nh = 0, fn = 0, cyc = 0;

  mcd_top i_mcd_top (.aclk, .aresetn, .s_awaddr, .s_awprot, .s_awvalid, .s_awready, .s_wdata,
    .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arprot,
    .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .cur_sp, .cur_sc,
    .cur_psl, .inst_pc, .mchk_req(rq[0]), .mm_exc, .ksnv_req(rq[1]), .soft_err_req(rq[2]),
    .hard_err_req(rq[3]), .ext_req, .ext_level, .ext_vector, .frame_we, .frame_addr,
    .frame_data, .req_accept, .disp_valid, .disp_addr, .disp_ipl, .disp_params, .disp_abort,
    .disp_istack, .dbl_halt, .mchk_busy, .irq);
  mcd_ext_irq i_mcd_ext_irq (.aclk, .aresetn, .req_accept, .ext_req, .ext_level, .ext_vector);

  always #5 aclk = ~aclk;

  // ----------------------------------------
  // Monitor and timeout
  // ----------------------------------------
  always @(posedge aclk) begin
    cyc++;
    if (frame_we === 1'b1) begin
      fa[fn%3] = frame_addr;
      fd[fn%3] = frame_data;
      fn++;
    end
    if (disp_valid === 1'b1) begin
      d_addr = disp_addr;
      d_ipl = disp_ipl;
      d_par = disp_params;
      d_abt = disp_abort;
      d_ist = disp_istack;
      nd++;
    end
    if (dbl_halt === 1'b1) nh++;
    if (cyc == 6000) begin
      fails++;
      end_sim();
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_awready === 1'b1) s_awvalid <= 1'b0;
      if (s_wready === 1'b1) s_wvalid <= 1'b0;
    end while (s_bvalid !== 1'b1);
    s_bready <= 1'b0;
    rsp = s_bresp;
  endtask
  task automatic rdr(input logic [ADDR_W-1:0] a);
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_arready === 1'b1) s_arvalid <= 1'b0;
    end while (s_rvalid !== 1'b1);
    s_rready <= 1'b0;
    rd = s_rdata;
    rsp = s_rresp;
  endtask
  task automatic fire(input int n);
    @(posedge aclk);
    rq[n] <= 1'b1;
    do @(posedge aclk); while (req_accept !== 1'b1);
    rq[n] <= 1'b0;
    repeat (6) @(posedge aclk);
  endtask
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rdr(ADDR_VTB);
    chk(rd, 32'h0000_0000, "base reset");
    wr(ADDR_VTB, 32'hFFFF_FFFF);
    chk(32'(rsp), 32'h0, "base write resp");
    rdr(ADDR_VTB);
    chk(rd, 32'h3FFF_FE00, "base zero fields");
    rdr(ADDR_ACK);
    chk(rd, 32'h0000_0000, "ack read");
    chk(32'(rsp), 32'h0, "ack resp");
    rdr(12'hFF0);
    chk(32'(rsp), 32'h2, "unmapped resp");
    wr(12'hFF0, 32'h0000_0001);
    chk(32'(rsp), 32'h2, "unmapped write resp");
    wr(ADDR_VTB, BASE);
    $display("Test registers done");
    fire(0);
    chk(fa[0], cur_sp + 32'd24, "sc addr");
    chk(fd[0], cur_sc, "sc word");
    chk(fa[1], cur_sp + 32'd28, "pc addr");
    chk(fd[1], inst_pc, "pc word");
    chk(fa[2], cur_sp + 32'd32, "psl addr");
    chk(fd[2], cur_psl, "psl word");
    chk(d_addr, BASE + 32'h4, "mchk vector");
    chk({28'h0, d_par}, 32'h6, "mchk params");
    chk({31'h0, d_abt}, 32'h1, "mchk abort");
    chk({27'h0, d_ipl}, 32'h17, "mchk level");
    chk({31'h0, mchk_busy}, 32'h1, "busy set");
    rdr(ADDR_STATE);
    chk(rd, 32'h9, "state busy idle");
    fire(0);
    @(posedge aclk);
    mm_exc <= 1'b1;
    @(posedge aclk);
    mm_exc <= 1'b0;
    repeat (4) @(posedge aclk);
    chk(32'(nh), 32'd2, "double halts");
    chk(32'(nd), 32'd1, "no dispatch in halt");
    wr(ADDR_ACK, 32'h0000_0001);
    chk({31'h0, mchk_busy}, 32'h1, "busy kept");
    wr(ADDR_ACK, 32'h0000_0000);
    repeat (2) @(posedge aclk);
    chk({31'h0, mchk_busy}, 32'h0, "busy cleared");
    fire(0);
    chk(32'(nh) + 32'(nd), 32'd4, "reporting resumed");
    wr(ADDR_ACK, 32'h0000_0000);
    $display("Test machine check done");
    for (int i = 1; i < 4; i++) begin
      fire(i);
      chk(d_addr, BASE + voff[i], "table vector");
      chk({27'h0, d_ipl}, vipl[i], "table level");
      chk({28'h0, d_par}, 32'h0, "table params");
      chk({31'h0, d_abt}, 32'(i == 1), "table abort");
      if (i == 1) chk({31'h0, d_ist}, 32'h1, "interrupt stack");
    end
    $display("Test fixed vectors done");
    i_mcd_ext_irq.send(16'h0104, 2'd1);
    repeat (3) @(posedge aclk);
    chk(d_addr, BASE + 32'h104, "ext vector");
    chk({27'h0, d_ipl}, 32'h15, "ext request level");
    i_mcd_ext_irq.send(16'h0201, 2'd2);
    repeat (3) @(posedge aclk);
    chk(d_addr, BASE + 32'h200, "ext vector odd");
    chk({27'h0, d_ipl}, 32'h17, "ext level kept");
    $display("Test external vectors done");
    rdr(ADDR_STATUS);
    chk(rd, 32'h7, "status events");
    chk({31'h0, irq}, 32'h0, "irq masked");
    wr(ADDR_MASK, 32'h7);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h1, "irq raised");
    wr(ADDR_STATUS, 32'h7);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    rdr(ADDR_STATUS);
    chk(rd, 32'h0, "status cleared");
    $display("Test interrupt done");
    end_sim();
  end
endmodule
